// file: hw/xpb_pkg.sv
// External port bank decoder: shared constants and carrier types.
// Assumes one clock domain; all users write xpb_pkg::name.
package xpb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Address map

  localparam int unsigned NUM_BANKS  = 4;
  localparam int unsigned OFF_W      = 26;
  localparam int unsigned COL_W      = 10;
  localparam int unsigned BANK_MSB   = 27;
  localparam int unsigned BANK_LSB   = 26;

  localparam logic [3:0]  TOP_NIBBLE = 4'h0;
  localparam logic [31:0] BANK0_LO   = 32'h0020_0000;
  localparam logic [25:0] ASYNC_WIN  = 26'h07f_ffff;
  localparam logic [25:0] SDRAM_WIN  = 26'h3ff_ffff;
  localparam logic [NUM_BANKS-1:0][31:0] BANK_BASE = {
    32'h0c00_0000, 32'h0800_0000, 32'h0400_0000, 32'h0000_0000
  };

  localparam logic [31:0] FETCH_NW_LO = 32'h0020_0000;
  localparam logic [31:0] FETCH_NW_HI = 32'h005f_ffff;
  localparam logic [31:0] FETCH_SW_LO = 32'h0060_0000;
  localparam logic [31:0] FETCH_SW_HI = 32'h00ff_ffff;
  localparam logic [1:0]  FETCH_BANK  = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes, lanes and timing

  localparam logic [4:0]  MIN_SIZE_BITS = 5'h14;
  localparam logic [2:0]  MAX_SIZE_CODE = 3'h6;
  localparam int unsigned LANE_W        = 32;
  localparam int unsigned FETCH_W       = 48;
  localparam int unsigned DATA_W        = 64;
  localparam logic [4:0]  SYNC_LAT      = 5'h02;
  localparam logic [4:0]  CNT_ZERO      = 5'h00;
  localparam logic [3:0]  SEL_IDLE      = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // Types

  typedef enum logic [2:0] {
    XPB_IDLE   = 3'h0,
    XPB_SETUP  = 3'h1,
    XPB_STROBE = 3'h3,
    XPB_HOLD   = 3'h2,
    XPB_ACT    = 3'h6,
    XPB_CAS    = 3'h7,
    XPB_PRE    = 3'h5
  } xpb_state_t;

  typedef struct packed {
    logic [31:0]       addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              simd;
    logic              fetch;
  } xpb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              err;
    logic              short_word;
  } xpb_rsp_t;

  typedef struct packed {
    logic              hit;
    logic [1:0]        bank;
    logic [OFF_W-1:0]  offset;
    logic              fetch_ok;
    logic              short_word;
  } xpb_dec_t;

  typedef struct packed {
    logic [3:0] setup;
    logic [3:0] strobe;
    logic [3:0] hold;
  } xpb_async_tim_t;

  typedef struct packed {
    logic [3:0] rcd;
    logic [3:0] cas_lat;
    logic [3:0] rp;
  } xpb_sdram_tim_t;

endpackage

// file: hw/xpb_arbiter.sv
// Core versus DMA arbiter for the external port.
// Assumes the engine takes a grant in any cycle that engine_idle is high.
`timescale 1ns/100ps
module xpb_arbiter (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             core_valid,
  input  xpb_pkg::xpb_req_t     core_req,
  input  wire logic             dma_valid,
  input  xpb_pkg::xpb_req_t     dma_req,
  input  wire logic             engine_idle,
  output logic                  core_ready,
  output logic                  dma_ready,
  output logic                  grant_valid,
  output xpb_pkg::xpb_req_t     grant_req,
  output logic                  grant_dma
);

  logic last_dma_q;
  logic last_dma_d;
  logic pick_dma;

  // Alternate when both ask, so neither starves
  always_comb begin
    pick_dma    = dma_valid & (~core_valid | ~last_dma_q);
    grant_valid = engine_idle & (core_valid | dma_valid);
    core_ready  = engine_idle & ~pick_dma;
    dma_ready   = engine_idle & pick_dma;
    grant_dma   = pick_dma;
    grant_req   = pick_dma ? dma_req : core_req;
    last_dma_d  = grant_valid ? pick_dma : last_dma_q;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_dma_q <= 1'b0;
    end else begin
      last_dma_q <= last_dma_d;
    end
  end

endmodule

// file: hw/xpb_bank_decode.sv
// Address to bank decoder with instruction fetch window check.
// Purely combinational; bank type comes from static configuration.
`timescale 1ns/100ps
module xpb_bank_decode (
  input  wire logic [31:0]       addr,
  input  wire logic [3:0]        bank_is_sdram,
  output xpb_pkg::xpb_dec_t      dec
);

  function automatic logic in_range(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  logic [1:0]  bank;
  logic [25:0] win;
  logic [31:0] base;
  logic        above_lo;

  always_comb begin
    bank     = addr[xpb_pkg::BANK_MSB:xpb_pkg::BANK_LSB];
    base     = xpb_pkg::BANK_BASE[bank];
    // Window size follows the bank's controller type
    win      = bank_is_sdram[bank] ? xpb_pkg::SDRAM_WIN
                                   : xpb_pkg::ASYNC_WIN;
    above_lo = (bank != 2'h0) || (addr >= xpb_pkg::BANK0_LO);
    dec.bank = bank;
    // Fixed base, no compaction of partial banks
    dec.offset = addr[xpb_pkg::OFF_W-1:0] - base[xpb_pkg::OFF_W-1:0];
    dec.hit  = (addr[31:28] == xpb_pkg::TOP_NIBBLE) && above_lo &&
               (addr[xpb_pkg::OFF_W-1:0] <= win);
    dec.short_word = in_range(addr, xpb_pkg::FETCH_SW_LO,
                              xpb_pkg::FETCH_SW_HI);
    dec.fetch_ok = dec.hit && (bank == xpb_pkg::FETCH_BANK) &&
                   (in_range(addr, xpb_pkg::FETCH_NW_LO,
                             xpb_pkg::FETCH_NW_HI) ||
                    dec.short_word);
  end

endmodule

// file: hw/xpb_port.sv
// External port: arbitration, bank decode, async and SDRAM sequencing.
// Assumes external devices are 16-bit parts and pin data is asynchronous.
//
// Behaviour
// - Arbitrate core and DMA, one grant
// - Four active-low bank select outputs
// - Async bank windows: 6M then 8M words
// - Partial banks keep fixed window bases
// - Per-bank async timing applied each access
// - SDRAM bank windows: 62M then 64M words
// - SDRAM bank size 4M to 256M bytes
// - Programmable SDRAM timing for slow parts
// - SIMD SDRAM access uses full 64 bits
// - Instruction fetch only from bank 0
// - Fetch windows: traditional then compressed space
// - Fetch returns 48 bits per access, 64 for a SIMD fetch from SDRAM
`timescale 1ns/100ps
module xpb_port (
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire logic                      core_valid,
  input  xpb_pkg::xpb_req_t              core_req,
  output logic                           core_ready,
  output logic                           core_done,
  output xpb_pkg::xpb_rsp_t              core_rsp,
  input  wire logic                      dma_valid,
  input  xpb_pkg::xpb_req_t              dma_req,
  output logic                           dma_ready,
  output logic                           dma_done,
  output xpb_pkg::xpb_rsp_t              dma_rsp,
  input  wire logic [3:0]                bank_is_sdram,
  input  xpb_pkg::xpb_async_tim_t [3:0]  async_tim,
  input  wire logic [3:0][2:0]           sdram_size_code,
  input  xpb_pkg::xpb_sdram_tim_t        sdram_tim,
  output logic [3:0]                     bank_select_lines_n,
  output logic [25:0]                    mem_addr,
  output logic [63:0]                    external_port_data_bus_wr,
  output logic [1:0]                     external_port_data_bus_oe,
  input  wire logic [63:0]               external_port_data_bus_rd,
  output logic                           mem_rd_n,
  output logic                           mem_wr_n,
  output logic                           sdram_ras_n,
  output logic                           sdram_cas_n,
  output logic                           sdram_we_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [25:0] size_mask(input logic [2:0] code);
    logic [2:0]  c;
    logic [26:0] one;
    logic [26:0] m;
    c   = (code > xpb_pkg::MAX_SIZE_CODE) ? xpb_pkg::MAX_SIZE_CODE : code;
    one = 27'h1 << (xpb_pkg::MIN_SIZE_BITS + {2'h0, c});
    m   = one - 27'h1;
    size_mask = m[25:0];
  endfunction

  function automatic logic [4:0] wide(input logic [3:0] v);
    wide = {1'b0, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration and decode

  logic              engine_idle;
  logic              grant_valid;
  logic              grant_dma;
  xpb_pkg::xpb_req_t grant_req;
  xpb_pkg::xpb_dec_t dec;

  xpb_arbiter u_arb (
    .mclk        (mclk),
    .rstn        (rstn),
    .core_valid  (core_valid),
    .core_req    (core_req),
    .dma_valid   (dma_valid),
    .dma_req     (dma_req),
    .engine_idle (engine_idle),
    .core_ready  (core_ready),
    .dma_ready   (dma_ready),
    .grant_valid (grant_valid),
    .grant_req   (grant_req),
    .grant_dma   (grant_dma)
  );

  xpb_bank_decode u_dec (
    .addr          (grant_req.addr),
    .bank_is_sdram (bank_is_sdram),
    .dec           (dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin data synchroniser

  logic [63:0] rd_meta_q;
  logic [63:0] rd_sync_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_meta_q <= 64'h0;
      rd_sync_q <= 64'h0;
    end else begin
      rd_meta_q <= external_port_data_bus_rd;
      rd_sync_q <= rd_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access engine

  xpb_pkg::xpb_state_t st_q, st_d;
  xpb_pkg::xpb_req_t   req_q, req_d;
  logic [4:0]          cnt_q, cnt_d;
  logic [1:0]          bank_q, bank_d;
  logic [25:0]         off_q, off_d;
  logic                dma_q, dma_d;
  logic                sdram_q, sdram_d;
  logic                short_q, short_d;
  logic                err_q, err_d;
  logic [63:0]         rdata_q, rdata_d;
  logic [3:0]          sel_n_q, sel_n_d;
  logic [25:0]         addr_q, addr_d;
  logic [63:0]         dout_q, dout_d;
  logic [1:0]          oe_q, oe_d;
  logic                rd_n_q, rd_n_d;
  logic                wr_n_q, wr_n_d;
  logic                ras_n_q, ras_n_d;
  logic                cas_n_q, cas_n_d;
  logic                we_n_q, we_n_d;
  logic                done_core_q, done_core_d;
  logic                done_dma_q, done_dma_d;
  logic                finish;
  logic                capture;
  logic                cnt_end;
  logic [4:0]          cnt_dec;
  logic [25:0]         masked;
  logic [1:0]          wr_lanes;

  assign engine_idle = (st_q == xpb_pkg::XPB_IDLE);

  always_comb begin
    st_d        = st_q;
    req_d       = req_q;
    cnt_d       = cnt_q;
    bank_d      = bank_q;
    off_d       = off_q;
    dma_d       = dma_q;
    sdram_d     = sdram_q;
    short_d     = short_q;
    err_d       = err_q;
    rdata_d     = rdata_q;
    sel_n_d     = sel_n_q;
    addr_d      = addr_q;
    dout_d      = dout_q;
    oe_d        = oe_q;
    rd_n_d      = rd_n_q;
    wr_n_d      = wr_n_q;
    ras_n_d     = 1'b1;
    cas_n_d     = 1'b1;
    we_n_d      = 1'b1;
    done_core_d = 1'b0;
    done_dma_d  = 1'b0;
    finish      = 1'b0;
    capture     = 1'b0;
    cnt_end     = (cnt_q == xpb_pkg::CNT_ZERO);
    cnt_dec     = cnt_q - 5'h01;
    masked      = dec.offset & size_mask(sdram_size_code[dec.bank]);
    // Upper lane only for SIMD on SDRAM
    wr_lanes    = {req_q.simd & sdram_q, 1'b1};
    case (st_q)
      xpb_pkg::XPB_IDLE: begin
        if (grant_valid) begin
          req_d   = grant_req;
          dma_d   = grant_dma;
          bank_d  = dec.bank;
          short_d = dec.short_word;
          sdram_d = bank_is_sdram[dec.bank];
          dout_d  = grant_req.wdata;
          if (!dec.hit || (grant_req.fetch && !dec.fetch_ok)) begin
            // Refused at once, no select driven
            err_d       = 1'b1;
            rdata_d     = 64'h0;
            done_core_d = ~grant_dma;
            done_dma_d  = grant_dma;
          end else begin
            err_d   = 1'b0;
            sel_n_d = ~(4'h1 << dec.bank);
            if (bank_is_sdram[dec.bank]) begin
              off_d   = masked;
              addr_d  = masked >> xpb_pkg::COL_W;
              ras_n_d = 1'b0;
              cnt_d   = wide(sdram_tim.rcd);
              st_d    = xpb_pkg::XPB_ACT;
            end else begin
              off_d  = dec.offset;
              addr_d = dec.offset;
              cnt_d  = wide(async_tim[dec.bank].setup);
              st_d   = xpb_pkg::XPB_SETUP;
            end
          end
        end
      end
      xpb_pkg::XPB_SETUP: begin
        if (cnt_end) begin
          rd_n_d = req_q.we;
          wr_n_d = ~req_q.we;
          oe_d   = req_q.we ? 2'h1 : 2'h0;
          // Stretch strobe to cover the synchroniser
          cnt_d  = wide(async_tim[bank_q].strobe) + xpb_pkg::SYNC_LAT;
          st_d   = xpb_pkg::XPB_STROBE;
        end else begin
          cnt_d = cnt_dec;
        end
      end
      xpb_pkg::XPB_STROBE: begin
        if (cnt_end) begin
          capture = ~req_q.we;
          rd_n_d  = 1'b1;
          wr_n_d  = 1'b1;
          cnt_d   = wide(async_tim[bank_q].hold);
          st_d    = xpb_pkg::XPB_HOLD;
        end else begin
          cnt_d = cnt_dec;
        end
      end
      xpb_pkg::XPB_HOLD: begin
        if (cnt_end) begin
          finish = 1'b1;
        end else begin
          cnt_d = cnt_dec;
        end
      end
      xpb_pkg::XPB_ACT: begin
        if (cnt_end) begin
          cas_n_d = 1'b0;
          we_n_d  = ~req_q.we;
          addr_d  = {16'h0, off_q[xpb_pkg::COL_W-1:0]};
          oe_d    = req_q.we ? wr_lanes : 2'h0;
          cnt_d   = req_q.we ? xpb_pkg::CNT_ZERO
                    : wide(sdram_tim.cas_lat) + xpb_pkg::SYNC_LAT;
          st_d    = xpb_pkg::XPB_CAS;
        end else begin
          cnt_d = cnt_dec;
        end
      end
      xpb_pkg::XPB_CAS: begin
        if (cnt_end) begin
          capture = ~req_q.we;
          oe_d    = 2'h0;
          ras_n_d = 1'b0;
          we_n_d  = 1'b0;
          cnt_d   = wide(sdram_tim.rp);
          st_d    = xpb_pkg::XPB_PRE;
        end else begin
          cnt_d = cnt_dec;
        end
      end
      xpb_pkg::XPB_PRE: begin
        if (cnt_end) begin
          finish = 1'b1;
        end else begin
          cnt_d = cnt_dec;
        end
      end
      default: begin
        st_d    = xpb_pkg::XPB_IDLE;
        sel_n_d = xpb_pkg::SEL_IDLE;
      end
    endcase
    if (capture) begin
      if (req_q.simd && sdram_q) begin
        rdata_d = rd_sync_q;
      end else if (req_q.fetch) begin
        rdata_d = {16'h0, rd_sync_q[xpb_pkg::FETCH_W-1:0]};
      end else begin
        rdata_d = {32'h0, rd_sync_q[xpb_pkg::LANE_W-1:0]};
      end
    end
    if (finish) begin
      sel_n_d     = xpb_pkg::SEL_IDLE;
      oe_d        = 2'h0;
      done_core_d = ~dma_q;
      done_dma_d  = dma_q;
      st_d        = xpb_pkg::XPB_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q        <= xpb_pkg::XPB_IDLE;
      req_q       <= '0;
      cnt_q       <= 5'h00;
      bank_q      <= 2'h0;
      off_q       <= 26'h0;
      dma_q       <= 1'b0;
      sdram_q     <= 1'b0;
      short_q     <= 1'b0;
      err_q       <= 1'b0;
      rdata_q     <= 64'h0;
      sel_n_q     <= xpb_pkg::SEL_IDLE;
      addr_q      <= 26'h0;
      dout_q      <= 64'h0;
      oe_q        <= 2'h0;
      rd_n_q      <= 1'b1;
      wr_n_q      <= 1'b1;
      ras_n_q     <= 1'b1;
      cas_n_q     <= 1'b1;
      we_n_q      <= 1'b1;
      done_core_q <= 1'b0;
      done_dma_q  <= 1'b0;
    end else begin
      st_q        <= st_d;
      req_q       <= req_d;
      cnt_q       <= cnt_d;
      bank_q      <= bank_d;
      off_q       <= off_d;
      dma_q       <= dma_d;
      sdram_q     <= sdram_d;
      short_q     <= short_d;
      err_q       <= err_d;
      rdata_q     <= rdata_d;
      sel_n_q     <= sel_n_d;
      addr_q      <= addr_d;
      dout_q      <= dout_d;
      oe_q        <= oe_d;
      rd_n_q      <= rd_n_d;
      wr_n_q      <= wr_n_d;
      ras_n_q     <= ras_n_d;
      cas_n_q     <= cas_n_d;
      we_n_q      <= we_n_d;
      done_core_q <= done_core_d;
      done_dma_q  <= done_dma_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign bank_select_lines_n       = sel_n_q;
  assign mem_addr                  = addr_q;
  assign external_port_data_bus_wr = dout_q;
  assign external_port_data_bus_oe = oe_q;
  assign mem_rd_n                  = rd_n_q;
  assign mem_wr_n                  = wr_n_q;
  assign sdram_ras_n               = ras_n_q;
  assign sdram_cas_n               = cas_n_q;
  assign sdram_we_n                = we_n_q;
  assign core_done                 = done_core_q;
  assign dma_done                  = done_dma_q;
  assign core_rsp.rdata            = rdata_q;
  assign core_rsp.err              = err_q;
  assign core_rsp.short_word       = short_q;
  assign dma_rsp                   = core_rsp;

endmodule

// file: test/xpb_port_props.sv
// Checker for the external port: select, arbitration, timing relations.
// Assumes one clock domain; bound into every xpb_port instance.
`timescale 1ns/100ps
module xpb_port_props (
  input wire logic                     mclk,
  input wire logic                     rstn,
  input wire logic                     core_valid,
  input xpb_pkg::xpb_req_t             core_req,
  input wire logic                     core_ready,
  input wire logic                     core_done,
  input xpb_pkg::xpb_rsp_t             core_rsp,
  input wire logic                     dma_valid,
  input wire logic                     dma_ready,
  input wire logic [3:0]               bank_is_sdram,
  input xpb_pkg::xpb_async_tim_t [3:0] async_tim,
  input wire logic [3:0]               bank_select_lines_n,
  input wire logic [1:0]               external_port_data_bus_oe,
  input wire logic                     mem_rd_n,
  input wire logic                     mem_wr_n,
  input wire logic                     sdram_ras_n,
  input wire logic                     sdram_cas_n,
  input wire logic                     sdram_we_n
);
  logic [4:0] low_cnt_q;
  logic [4:0] low_cnt_d;
  logic [1:0] sel_idx;
  logic       bad_take;
  logic       take;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  assign take     = core_valid && core_ready;
  assign bad_take = take && core_req.addr[31:28] != 4'h0;

  always_comb begin
    low_cnt_d = mem_rd_n ? 5'h00 : low_cnt_q + 5'h01;
    sel_idx   = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (!bank_select_lines_n[i])
        sel_idx = 2'(i);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      low_cnt_q <= 5'h00;
    else
      low_cnt_q <= low_cnt_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  one_select_a: assert property ($onehot0(~bank_select_lines_n))
    else $error("more than one bank select low");
  unmapped_nosel_a: assert property (
    bad_take |=> bank_select_lines_n == 4'hf [*2])
    else $error("select low for unmapped address");
  unmapped_err_a: assert property (
    bad_take |-> ##[1:2] (core_done && core_rsp.err))
    else $error("unmapped address not refused");
  fetch_bank_a: assert property (
    take && core_req.fetch && core_req.addr[27:26] != 2'h0
    |-> ##[1:2] (core_done && core_rsp.err))
    else $error("fetch outside bank 0 accepted");
  arb_single_a: assert property (
    core_valid && dma_valid |-> !(core_ready && dma_ready))
    else $error("both requesters ready together");
  busy_ready_a: assert property (
    bank_select_lines_n != 4'hf |-> !core_ready && !dma_ready)
    else $error("ready while an access is running");
  strobe_sel_a: assert property (
    !mem_rd_n || !mem_wr_n |-> bank_select_lines_n != 4'hf)
    else $error("strobe without bank select");
  strobe_len_a: assert property (
    $rose(mem_rd_n) |-> low_cnt_q == 5'(async_tim[sel_idx].strobe) + 5'h03)
    else $error("read strobe length differs from bank timing");
  hi_lane_a: assert property (
    external_port_data_bus_oe[1]
    |-> (bank_is_sdram & ~bank_select_lines_n) != 4'h0)
    else $error("high lane driven outside an SDRAM access");
  act_cas_a: assert property (
    !sdram_ras_n && sdram_cas_n && sdram_we_n |-> ##[1:17] !sdram_cas_n)
    else $error("no column command after activate");
endmodule

bind xpb_port xpb_port_props props_u (
  .mclk, .rstn, .core_valid, .core_req, .core_ready, .core_done, .core_rsp,
  .dma_valid, .dma_ready, .bank_is_sdram, .async_tim, .bank_select_lines_n,
  .external_port_data_bus_oe, .mem_rd_n, .mem_wr_n, .sdram_ras_n,
  .sdram_cas_n, .sdram_we_n
);

// file: test/xpb_mem_model.sv
// External memory stand-in: answers reads of any selected bank.
// Assumes 16-bit parts side by side; bus toggles when not selected.
`timescale 1ns/100ps
module xpb_mem_model (
  input  wire logic        mclk,
  input  wire logic [3:0]  sel_n,
  input  wire logic [1:0]  oe,
  output logic      [63:0] rd_data
);
  logic [1:0] bank;

  initial rd_data = 64'h0;

  always_comb begin
    bank = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (!sel_n[i])
        bank = 2'(i);
    end
  end

  // Each 16-bit lane tagged with the bank; released bus toggles
  always @(posedge mclk) begin
    if (sel_n != 4'hf && oe == 2'h0)
      rd_data <= 64'h4000_3000_2000_1000 | {4{14'h0, bank}};
    else
      rd_data <= ~rd_data;
  end
endmodule

// file: test/xpb_port_test.sv
// Testbench for the external port with memory model on the pins.
// Assumes banks 0,1,3 async and bank 2 SDRAM, static timing.
`timescale 1ns/100ps
module test_xpb_port;
  localparam time DLY = 1;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic core_valid = 1'b0;
  logic dma_valid = 1'b0;
  xpb_pkg::xpb_req_t core_req = '0;
  xpb_pkg::xpb_req_t dma_req = '0;
  xpb_pkg::xpb_rsp_t core_rsp;
  xpb_pkg::xpb_rsp_t dma_rsp;
  logic core_ready, core_done, dma_ready, dma_done;
  logic [3:0] bank_is_sdram = 4'b0100;
  xpb_pkg::xpb_async_tim_t [3:0] async_tim = {12'h243, 24'h0, 12'h121};
  logic [3:0][2:0] sdram_size_code = {4{3'h6}};
  xpb_pkg::xpb_sdram_tim_t sdram_tim = 12'h111;
  logic [3:0] bank_select_lines_n;
  logic [25:0] mem_addr;
  logic [63:0] external_port_data_bus_wr, external_port_data_bus_rd;
  logic [1:0] external_port_data_bus_oe;
  logic mem_rd_n, mem_wr_n, sdram_ras_n, sdram_cas_n, sdram_we_n;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int fin [2];
  logic saw_sel, saw_hi;
  logic [25:0] seen_addr;
  logic [63:0] seen_wr;

  xpb_port dut_u (
    .mclk, .rstn, .core_valid, .core_req, .core_ready, .core_done,
    .core_rsp, .dma_valid, .dma_req, .dma_ready, .dma_done, .dma_rsp,
    .bank_is_sdram, .async_tim, .sdram_size_code, .sdram_tim,
    .bank_select_lines_n, .mem_addr, .external_port_data_bus_wr,
    .external_port_data_bus_oe, .external_port_data_bus_rd, .mem_rd_n,
    .mem_wr_n, .sdram_ras_n, .sdram_cas_n, .sdram_we_n
  );
  xpb_mem_model mem_u (.mclk(mclk), .sel_n(bank_select_lines_n),
    .oe(external_port_data_bus_oe), .rd_data(external_port_data_bus_rd));

  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (bank_select_lines_n != 4'hf)
      saw_sel = 1'b1;
    if (external_port_data_bus_oe[1])
      saw_hi = 1'b1;
    if (!mem_rd_n)
      seen_addr = mem_addr;
    if (external_port_data_bus_oe[0])
      seen_wr = external_port_data_bus_wr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  function automatic logic [63:0] pat(input logic [1:0] b);
    return 64'h4000_3000_2000_1000 | {4{14'h0, b}};
  endfunction

  task automatic chk(input string nm, input logic [63:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One transfer from core (d=0) or DMA (d=1); n = edges from take to done
  task automatic xfer(input bit d, input logic [31:0] a, input logic w, s,
                      f, output xpb_pkg::xpb_rsp_t r, output int n);
    xpb_pkg::xpb_req_t q;
    int k;
    q = '{a, 64'hc3c3_5a5a_0f0f_9696, w, s, f};
    k = 0;
    n = 0;
    if (d) begin
      dma_req = q;
      dma_valid = 1'b1;
    end else begin
      core_req = q;
      core_valid = 1'b1;
    end
    do begin
      @(negedge mclk);
      k++;
    end while (!(d ? dma_ready : core_ready) && k < 50);
    @(posedge mclk);
    #DLY;
    if (d) dma_valid = 1'b0;
    else core_valid = 1'b0;
    do begin
      if (n > 0) @(posedge mclk);
      if (n > 0) #DLY;
      n++;
    end while (!(d ? dma_done : core_done) && n < 100);
    if (k >= 50 || n >= 100) begin
      n_mismatch++;
      test_done();
    end
    r = d ? dma_rsp : core_rsp;
    fin[d] = cyc;
    // Let an edge pass so the next request never lands in this time step
    @(posedge mclk);
    #DLY;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_async();
    logic [31:0] ad [3] = '{32'h0070_0000,
                            32'h0400_0010, 32'h0c7f_ffff};
    int lat [3] = '{10, 6, 15};
    logic [1:0] bk [3] = '{2'h0, 2'h1, 2'h3};
    xpb_pkg::xpb_rsp_t r;
    int n;
    for (int i = 0; i < 3; i++) begin
      xfer(i == 1, ad[i], 1'b0, 1'b0, 1'b0, r, n);
      chk("latency", n, lat[i]);
      chk("err", r.err, 1'b0);
      chk("rdata", r.rdata, pat(bk[i]) & 64'hffff_ffff);
      chk("addr", seen_addr, ad[i][25:0]);
    end
    $display("t_async finished");
  endtask

  task automatic t_unmap();
    logic [31:0] ad [5] = '{32'h0080_0000, 32'h0480_0000, 32'h0010_0000,
                            32'h1000_0000, 32'h0c80_0000};
    xpb_pkg::xpb_rsp_t r;
    int n;
    foreach (ad[i]) begin
      saw_sel = 1'b0;
      xfer(1'b0, ad[i], 1'b0, 1'b0, 1'b0, r, n);
      chk("err", r.err, 1'b1);
      chk("rdata", r.rdata, 64'h0);
      chk("select", saw_sel, 1'b0);
    end
    xfer(1'b0, 32'h0bff_fffc, 1'b0, 1'b0, 1'b0, r, n);
    chk("err", r.err, 1'b0);
    $display("t_unmap finished");
  endtask

  task automatic t_sdram();
    xpb_pkg::xpb_rsp_t r;
    int n;
    xfer(1'b0, 32'h0800_0100, 1'b0, 1'b1, 1'b0, r, n);
    chk("latency", n, 9);
    chk("rdata", r.rdata, pat(2'h2));
    xfer(1'b1, 32'h0800_0104, 1'b0, 1'b0, 1'b0, r, n);
    chk("rdata", r.rdata, pat(2'h2) & 64'hffff_ffff);
    for (int s = 1; s >= 0; s--) begin
      saw_hi = 1'b0;
      seen_wr = 64'h0;
      xfer(1'b0, 32'h0800_0200, 1'b1, s[0], 1'b0, r, n);
      chk("latency", n, 6);
      chk("high lane", saw_hi, s[0]);
      chk("write data", seen_wr, 64'hc3c3_5a5a_0f0f_9696);
    end
    $display("t_sdram finished");
  endtask

  task automatic t_fetch();
    logic [31:0] ad [4] = '{32'h0020_0000, 32'h0060_0000, 32'h0400_0000,
                            32'h0080_0000};
    logic er [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic sw [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    xpb_pkg::xpb_rsp_t r;
    int n;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, ad[i], 1'b0, 1'b0, 1'b1, r, n);
      chk("err", r.err, er[i]);
      if (!er[i]) begin
        chk("short word", r.short_word, sw[i]);
        chk("rdata", r.rdata, pat(2'h0) & 64'hffff_ffff_ffff);
      end
    end
    $display("t_fetch finished");
  endtask

  task automatic t_arb();
    xpb_pkg::xpb_rsp_t rc, rd;
    int nc, nd;
    fork
      xfer(1'b0, 32'h0400_0000, 1'b0, 1'b0, 1'b0, rc, nc);
      xfer(1'b1, 32'h0c00_0004, 1'b0, 1'b0, 1'b0, rd, nd);
    join
    // Last grant went to the core, so round robin serves DMA first
    chk("dma first", fin[1] < fin[0], 1'b1);
    chk("core rdata", rc.rdata, pat(2'h1) & 64'hffff_ffff);
    chk("dma rdata", rd.rdata, pat(2'h3) & 64'hffff_ffff);
    $display("t_arb finished");
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    #DLY;
    rstn = 1'b1;
    chk("idle select", bank_select_lines_n, 4'hf);
    chk("idle ready", core_ready, 1'b1);
    t_async();
    t_unmap();
    t_sdram();
    t_fetch();
    t_arb();
    test_done();
  end
endmodule
